// ---- tcra_pkg.sv ----
// Notes on behaviour
// - Control bit 7 enables overflow and capture/compare interrupt sources.
// - Output enable 0 gives port latch; 1 gives 16-bit or high-byte PWM.
// - Polarity sets starting level of output waveform, low for 0.
// - Polarity reaches the pin only when output enable rises.
// - As input, without both edges, polarity picks the level that gates.
// - Low run bit runs low byte timer in dual mode only.
// - Main run bit runs high byte or full timer; zero holds count.
// - Capture-reload bit adds reload to capture on selected edges.
// - Both edges, reload and gate set: polarity skips one edge reload.
// - Single-shot in compare mode outputs one reload-to-overflow cycle.
// - Gated compare single-shot waits for nongated level, else starts.
// - Gated single-shot output is not supported in dual mode.
// - Capture single-shot halts until edge or ungate, runs to next edge.
// - Both edges: single-shot edge is falling for polarity 1, else rising.
// - Single-shot start edge sets no interrupt flag.
// - Gate bit lets pin gate the main timer, only as timer input.
// - Low byte timer and counter mode are never gated.
// - Control bits 15 to 8 read zero, writes ignored.
// - Instance without a pin drops polarity, gating and pin single-shot.
// - Width mode 0 is 16-bit, reset default; 1 is dual 8-bit.
// - Edge bits 00 compare; 01,10,11 rising, falling, both edges.
package tcra_pkg;
  localparam logic [7:0]  TCRA_CTRL_OFS    = 8'h00;
  localparam logic [7:0]  TCRA_CFG_OFS     = 8'h04;
  localparam logic [7:0]  TCRA_STAT_OFS    = 8'h08;
  localparam logic [7:0]  TCRA_VAL_OFS     = 8'h0C;
  localparam logic [7:0]  TCRA_RLD_OFS     = 8'h10;
  localparam logic [7:0]  TCRA_CMP_OFS     = 8'h14;
  localparam logic [15:0] TCRA_CTRL_RST    = 16'h0000;
  localparam logic [7:0]  TCRA_CTRL_MASK   = 8'hFF;
  localparam logic [3:0]  TCRA_CFG_MASK    = 4'hF;
  localparam logic [1:0]  TCRA_EDGE_NONE   = 2'h0;
  localparam logic [1:0]  TCRA_EDGE_RISE   = 2'h1;
  localparam logic [1:0]  TCRA_EDGE_FALL   = 2'h2;
  localparam logic [1:0]  TCRA_EDGE_BOTH   = 2'h3;
  localparam logic [31:0] TCRA_BAD_DATA    = 32'h0000_0000;

  typedef struct packed {
    logic irq_en;
    logic oe;
    logic pol;
    logic lo_run;
    logic run;
    logic cprl;
    logic ss;
    logic gate;
  } tcra_ctrl_s;

  typedef struct packed {
    logic       width_mode;
    logic [1:0] edge_sel;
    logic       counter_sel;
  } tcra_cfg_s;

  typedef enum logic [1:0] {
    TCRA_SS_IDLE = 2'b00,
    TCRA_SS_WAIT = 2'b01,
    TCRA_SS_RUN  = 2'b10
  } tcra_ss_e;
endpackage : tcra_pkg

// ---- tcra_timer.sv ----
`timescale 1ns/1ps
`default_nettype none
module tcra_timer
  import tcra_pkg::*;
#(
  parameter bit HAS_PIN = 1'b1
) (
  input  wire logic        ref_clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [7:0]  wb_adr_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic [31:0] wb_dat_in,
  output logic [31:0]      wb_dat_out,
  output logic             wb_ack_out,
  input  wire logic        pin_in,
  input  wire logic        port_latch_in,
  output logic             pin_out,
  output logic             pin_oe_n_out,
  output logic             irq_out
);
  // Time-zero guard on the pin parameter. Only two builds make
  // sense: a timer with its pin, or an internal timer with none. Any
  // other value would leave the pin qualifiers below half-defined.
  initial begin
    if (HAS_PIN !== 1'b0 && HAS_PIN !== 1'b1) begin
      $error("HAS_PIN must be 0 or 1");
    end
  end

  // Overview of the datapath
  // - One 16-bit counter register that also serves as two byte timers.
  // - The high byte, or the whole word, is the main timer; it alone
  //   sees the run bit, the gate, single-shot and capture.
  // - The low byte only ever compares and never sees the pin.
  // - Every count happens at the system clock; there is no divider.
  // - The compare register doubles as the capture register, so a
  //   capture overwrites whatever compare value software left there.

  ////////////////////////////////////////////////////////////////////////
  // Register state
  tcra_ctrl_s  ctrl_r;
  tcra_cfg_s   cfg_r;
  logic [15:0] val_r;
  logic [15:0] rld_r;
  logic [15:0] cmp_r;
  logic        ovf_r;
  logic        ccf_r;
  logic        lovf_r;
  logic        lccf_r;
  logic        wave_r;
  logic        lwave_r;
  logic        oe_d_r;
  logic        pin_s1_r;
  logic        pin_s2_r;
  logic        pin_d_r;
  tcra_ss_e    ss_st_r;
  tcra_ss_e    ss_st_nxt;
  logic [31:0] rdat_r;
  logic        ack_r;

  ////////////////////////////////////////////////////////////////////////
  // Bus decode
  wire bus_req  = wb_cyc_in & wb_stb_in & ~ack_r;
  wire bus_wr   = bus_req & wb_we_in;
  wire wr_ctrl  = bus_wr & (wb_adr_in == TCRA_CTRL_OFS) & wb_sel_in[0];
  wire wr_cfg   = bus_wr & (wb_adr_in == TCRA_CFG_OFS) & wb_sel_in[0];
  wire wr_stat  = bus_wr & (wb_adr_in == TCRA_STAT_OFS) & wb_sel_in[0];
  wire wr_val   = bus_wr & (wb_adr_in == TCRA_VAL_OFS);
  wire wr_rld   = bus_wr & (wb_adr_in == TCRA_RLD_OFS);
  wire wr_cmp   = bus_wr & (wb_adr_in == TCRA_CMP_OFS);
  // Upper bus bits are dropped on the floor: bits 15..8 stay zero
  wire [7:0] ctrl_wdat = wb_dat_in[7:0] & TCRA_CTRL_MASK;
  wire tcra_ctrl_s ctrl_w = tcra_ctrl_s'(ctrl_wdat);

  ////////////////////////////////////////////////////////////////////////
  // Mode decode
  wire dual     = cfg_r.width_mode;
  wire cnt_mode = cfg_r.counter_sel & HAS_PIN;
  wire cmp_mode = (cfg_r.edge_sel == TCRA_EDGE_NONE) & ~cnt_mode;
  wire cap_mode = (cfg_r.edge_sel != TCRA_EDGE_NONE) & ~cnt_mode;
  wire both     = cfg_r.edge_sel == TCRA_EDGE_BOTH;
  wire rise     = pin_s2_r & ~pin_d_r;
  wire fall     = ~pin_s2_r & pin_d_r;
  wire edge_hit = HAS_PIN &
                  ((cfg_r.edge_sel[0] & rise) | (cfg_r.edge_sel[1] & fall));
  // With both edges, polarity picks the single-shot edge
  wire ss_edge  = HAS_PIN & (both ? (ctrl_r.pol ? fall : rise)
                                  : edge_hit);
  // Gate allowed only as a timer input with output off
  wire gate_on  = HAS_PIN & ctrl_r.gate & ~ctrl_r.oe & ~cnt_mode
                  & ~(both & ctrl_r.cprl);
  // Polarity names the level at which counting is allowed
  wire gate_ok  = ~gate_on | (pin_s2_r == ctrl_r.pol);
  // Gated compare single-shot is refused in dual mode
  wire ss_gated = gate_on & ~(cmp_mode & dual);

  // Limitation: the gate is a level, sampled after the synchroniser,
  // so a gate pulse shorter than one clock may be missed entirely.
  // The same two-cycle latency applies to every edge the block sees.

  ////////////////////////////////////////////////////////////////////////
  // Count enables; single-shot overrides or delays the run bit
  wire ss_busy   = ss_st_r != TCRA_SS_IDLE;
  wire main_go   = (ss_busy ? (ss_st_r == TCRA_SS_RUN) : ctrl_r.run)
                   & gate_ok & (~cnt_mode | edge_hit);
  wire lo_go     = dual & ctrl_r.lo_run;
  wire [15:0] hi_max = dual ? 16'h00FF : 16'hFFFF;
  wire [15:0] main_v = dual ? {8'h00, val_r[15:8]} : val_r;
  wire main_ovf  = main_go & (main_v == hi_max);
  wire lo_ovf    = lo_go & (val_r[7:0] == 8'hFF);
  wire main_cmp  = main_go & ~cnt_mode & cmp_mode &
                   (dual ? (val_r[15:8] == cmp_r[15:8]) : (val_r == cmp_r));
  wire lo_cmp    = lo_go & (val_r[7:0] == cmp_r[7:0]);
  // Skip the reload on one edge when gate bit set with both edges
  wire skip_rld  = both & ctrl_r.gate & (ctrl_r.pol ? rise : fall);
  wire cap_ev    = cap_mode & edge_hit &
                   ~(ss_st_r == TCRA_SS_WAIT);
  wire do_rld    = cap_ev & ctrl_r.cprl & ~skip_rld;
  wire [15:0] cap_v = main_v;

  ////////////////////////////////////////////////////////////////////////
  // Single-shot sequencing
  // Placed after the count enables because the end of a compare shot
  // is the main overflow. IDLE hands the run bit back to software;
  // WAIT holds the count until the gate opens or the start edge comes;
  // RUN counts until overflow (compare) or the next shot edge (capture).
  // Code 2'b11 is never entered; the default parks it back in IDLE.
  always_comb begin
    ss_st_nxt = ss_st_r;
    unique case (ss_st_r)
      TCRA_SS_IDLE: begin
        if (wr_ctrl & ctrl_w.ss & ~cnt_mode) begin
          ss_st_nxt = TCRA_SS_WAIT;
        end
      end
      TCRA_SS_WAIT: begin
        if (cmp_mode & (~ss_gated | gate_ok)) begin
          ss_st_nxt = TCRA_SS_RUN;
        end else if (cap_mode & (ss_edge | (gate_on & gate_ok))) begin
          ss_st_nxt = TCRA_SS_RUN;
        end
      end
      TCRA_SS_RUN: begin
        if (cmp_mode & main_ovf) begin
          ss_st_nxt = TCRA_SS_IDLE;
        end else if (cap_mode & ss_edge) begin
          ss_st_nxt = TCRA_SS_IDLE;
        end
      end
      default: ss_st_nxt = TCRA_SS_IDLE;
    endcase
  end

  // Trade-off: the shot state is not cleared by a later write of zero
  // to the single-shot bit; the shot always runs to its natural end.
  // This keeps a measurement from being cut short by a stray write.

  // Next counter value, high part then low part
  // In dual mode the two bytes never carry into each other: each byte
  // wraps to its own half of the reload register. A capture reload
  // takes priority over an overflow reload on the main byte, since
  // both load the same value and the capture must not be lost.
  logic [15:0] val_nxt;
  always_comb begin
    val_nxt = val_r;
    if (dual) begin
      if (do_rld) begin
        val_nxt[15:8] = rld_r[15:8];
      end else if (main_ovf) begin
        val_nxt[15:8] = rld_r[15:8];
      end else if (main_go) begin
        val_nxt[15:8] = val_r[15:8] + 8'h01;
      end
      if (lo_ovf) begin
        val_nxt[7:0] = rld_r[7:0];
      end else if (lo_go) begin
        val_nxt[7:0] = val_r[7:0] + 8'h01;
      end
    end else if (do_rld | main_ovf) begin
      val_nxt = rld_r;
    end else if (main_go) begin
      val_nxt = val_r + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Control, config and value registers
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctrl_r  <= tcra_ctrl_s'(TCRA_CTRL_RST[7:0]);
      cfg_r   <= '0;
      val_r   <= 16'h0000;
      rld_r   <= 16'h0000;
      cmp_r   <= 16'h0000;
      ss_st_r <= TCRA_SS_IDLE;
    end else begin
      ss_st_r <= ss_st_nxt;
      if (wr_ctrl) begin
        ctrl_r <= ctrl_w;
      end else if (ss_st_nxt == TCRA_SS_IDLE) begin
        ctrl_r.ss <= 1'b0;  // Self clears when the shot is over
      end
      if (wr_cfg) begin
        cfg_r <= tcra_cfg_s'(wb_dat_in[3:0] & TCRA_CFG_MASK);
      end
      if (wr_val) begin
        val_r <= wb_dat_in[15:0];
      end else begin
        val_r <= val_nxt;
      end
      if (wr_rld) begin
        rld_r <= wb_dat_in[15:0];
      end
      if (wr_cmp) begin
        cmp_r <= wb_dat_in[15:0];
      end else if (cap_ev) begin
        cmp_r <= cap_v;      // Capture shares the compare register
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Flags: a hardware set beats a software clear in the same cycle
  // Software clears by writing one; a set that lands in the same cycle
  // as the clear survives, so no event is ever silently dropped.
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ovf_r  <= 1'b0;
      ccf_r  <= 1'b0;
      lovf_r <= 1'b0;
      lccf_r <= 1'b0;
    end else begin
      ovf_r  <= main_ovf | (ovf_r & ~(wr_stat & wb_dat_in[3]));
      ccf_r  <= main_cmp | cap_ev | (ccf_r & ~(wr_stat & wb_dat_in[1]));
      lovf_r <= lo_ovf | (lovf_r & ~(wr_stat & wb_dat_in[2]));
      lccf_r <= lo_cmp | (lccf_r & ~(wr_stat & wb_dat_in[0]));
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin synchroniser; stage one feeds stage two only
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pin_s1_r <= 1'b0;
      pin_s2_r <= 1'b0;
      pin_d_r  <= 1'b0;
    end else begin
      pin_s1_r <= pin_in;
      pin_s2_r <= pin_s1_r;
      pin_d_r  <= pin_s2_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Waveforms toggle on compare; a reload leaves them at their current level
  // The start level is loaded only on the rising edge of the output
  // enable, so software may change polarity freely while driving.
  // The low waveform is kept for symmetry; only the main one reaches
  // the pin.
  wire oe_rise = ctrl_r.oe & ~oe_d_r;
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wave_r  <= 1'b0;
      lwave_r <= 1'b0;
      oe_d_r  <= 1'b0;
    end else begin
      oe_d_r <= ctrl_r.oe;
      if (oe_rise) begin
        wave_r  <= ctrl_r.pol;
        lwave_r <= ctrl_r.pol;
      end else begin
        if (main_cmp) begin
          wave_r <= ~wave_r;
        end
        if (lo_cmp) begin
          lwave_r <= ~lwave_r;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin output; no pin means the latch path stays parked
  // The cycle the enable rises, the start level goes out directly,
  // since the waveform register only takes it on that same edge
  wire wave_out = oe_rise ? ctrl_r.pol : wave_r;
  wire pin_nxt = ctrl_r.oe ? wave_out : port_latch_in;
  wire irq_nxt = ctrl_r.irq_en & (ovf_r | ccf_r);
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pin_out      <= 1'b0;
      pin_oe_n_out <= 1'b1;
      irq_out      <= 1'b0;
    end else begin
      pin_out      <= HAS_PIN ? pin_nxt : 1'b0;
      pin_oe_n_out <= ~(HAS_PIN & ctrl_r.oe);
      irq_out      <= irq_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read mux; unmapped addresses read zero and still ack
  logic [31:0] rmux;
  always_comb begin
    rmux = TCRA_BAD_DATA;
    unique case (wb_adr_in)
      TCRA_CTRL_OFS: rmux = {24'h000000, ctrl_r};
      TCRA_CFG_OFS:  rmux = {28'h0000000, cfg_r};
      TCRA_STAT_OFS: rmux = {28'h0000000, ovf_r, lovf_r, ccf_r, lccf_r};
      TCRA_VAL_OFS:  rmux = {16'h0000, val_r};
      TCRA_RLD_OFS:  rmux = {16'h0000, rld_r};
      TCRA_CMP_OFS:  rmux = {16'h0000, cmp_r};
      default:       rmux = TCRA_BAD_DATA;
    endcase
  end

  // One-cycle ack; dropped after one cycle so the master can release
  // Read data is registered with the ack, so it stands exactly while
  // ack is high. A master that keeps its request up past the ack will
  // see a second transfer two cycles later; the bus decode masks the
  // request only in the ack cycle itself.
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ack_r  <= 1'b0;
      rdat_r <= 32'h0000_0000;
    end else begin
      ack_r  <= bus_req;
      rdat_r <= rmux;
    end
  end
  assign wb_ack_out = ack_r;
  assign wb_dat_out = rdat_r;
endmodule : tcra_timer
`default_nettype wire

// ---- tcra_pin_src.sv ----
`timescale 1ns/1ps
`default_nettype none
////////////////////
// Far-side pin driver; lag_in models a slow source
module tcra_pin_src (
  input  wire logic       ref_clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       want_in,
  input  wire logic [3:0] lag_in,
  output logic            pin_lvl_out
);
  logic [3:0] lag_r;
  // New level lands lag_in + 1 cycles after it is asked for
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      lag_r       <= 4'h0;
      pin_lvl_out <= 1'b0;
    end else if (pin_lvl_out == want_in) begin
      lag_r <= lag_in;
    end else if (lag_r != 4'h0) begin
      lag_r <= lag_r - 4'h1;
    end else begin
      pin_lvl_out <= want_in;
    end
  end
endmodule : tcra_pin_src
`default_nettype wire

// ---- tcra_timer_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
module tcra_timer_chk
  import tcra_pkg::*;
#(
  parameter bit HAS_PIN = 1'b1
) (
  input wire logic        ref_clk_in,
  input wire logic        rst_n_in,
  input wire logic        wb_cyc_in,
  input wire logic        wb_stb_in,
  input wire logic        wb_we_in,
  input wire logic [7:0]  wb_adr_in,
  input wire logic [3:0]  wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  input wire logic [31:0] wb_dat_out,
  input wire logic        wb_ack_out,
  input wire logic        pin_in,
  input wire logic        port_latch_in,
  input wire logic        pin_out,
  input wire logic        pin_oe_n_out,
  input wire logic        irq_out
);
  logic [7:0] ctl_r;
  wire        take   = wb_cyc_in & wb_stb_in & ~wb_ack_out;
  wire        rd_ack = wb_ack_out & ~wb_we_in;
  wire        ctl_wr = take & wb_we_in & wb_sel_in[0]
                       & (wb_adr_in == TCRA_CTRL_OFS);
  // Shadow of the control byte; single-shot may self-clear, so not used
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctl_r <= 8'h00;
    end else if (ctl_wr) begin
      ctl_r <= wb_dat_in[7:0];
    end
  end
  ////////////////////
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  ack_one_cycle_a: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack held longer than one cycle");
  ack_answer_a: assert property (take |=> wb_ack_out)
    else $error("request not answered next cycle");
  ack_cause_a: assert property (wb_ack_out |-> $past(wb_cyc_in & wb_stb_in))
    else $error("ack without request");
  ctrl_read_a: assert property (
    rd_ack && wb_adr_in == TCRA_CTRL_OFS |->
      wb_dat_out[31:8] == 24'h000000 && wb_dat_out[7:2] == ctl_r[7:2])
    else $error("control readback wrong");
  unmapped_zero_a: assert property (rd_ack && wb_adr_in > TCRA_CMP_OFS
    |-> wb_dat_out == 32'h00000000) else $error("unmapped read not zero");
  irq_enable_a: assert property (
    irq_out |-> ctl_r[7] || $past(ctl_r[7]))
    else $error("interrupt while disabled");
  pinless_a: assert property (!HAS_PIN |-> pin_oe_n_out)
    else $error("pinless instance drives pin");
  oe_source_a: assert property (
    !pin_oe_n_out |-> ctl_r[6] || $past(ctl_r[6]))
    else $error("pin driven with output disabled");
  latch_pass_a: assert property (
    HAS_PIN && $past(rst_n_in) && !$past(ctl_r[6]) |->
      pin_out == $past(port_latch_in))
    else $error("pin not carrying port latch");
  start_level_a: assert property (
    $fell(pin_oe_n_out) |-> pin_out == ctl_r[5])
    else $error("wrong starting level");
  cover property (take && wb_we_in);
  cover property ($fell(pin_oe_n_out));
  cover property ($rose(irq_out));
endmodule : tcra_timer_chk

bind tcra_timer tcra_timer_chk #(.HAS_PIN(HAS_PIN)) tcra_timer_chk_inst (
  .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .wb_cyc_in(wb_cyc_in),
  .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
  .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out),
  .wb_ack_out(wb_ack_out), .pin_in(pin_in), .port_latch_in(port_latch_in),
  .pin_out(pin_out), .pin_oe_n_out(pin_oe_n_out), .irq_out(irq_out));
`default_nettype wire

// ---- timer_control_a_run_gate_single_shot_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module timer_control_a_run_gate_single_shot_tb;
  import tcra_pkg::*;
  logic        ref_clk_in, rst_n_in, cyc, we, latch, want;
  logic [7:0]  adr;
  logic [3:0]  sel, lag;
  logic [31:0] wdat, rv, v;
  wire  [31:0] rdat;
  wire         ack, pin, src, pout, oe_n, oe_n2, irq;
  int          n_errors, n_tests, k;
  // Pin wire: timer drives it when enabled, else the far side
  assign pin = oe_n ? src : pout;
  tcra_timer tcra_timer_inst (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
    .wb_cyc_in(cyc), .wb_stb_in(cyc), .wb_we_in(we), .wb_adr_in(adr),
    .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack),
    .pin_in(pin), .port_latch_in(latch), .pin_out(pout),
    .pin_oe_n_out(oe_n), .irq_out(irq));
  // Pinless copy sees the same bus traffic
  tcra_timer #(.HAS_PIN(1'b0)) tcra_timer_inst2 (.ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in), .wb_cyc_in(cyc), .wb_stb_in(cyc), .wb_we_in(we),
    .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(),
    .wb_ack_out(), .pin_in(pin), .port_latch_in(latch), .pin_out(),
    .pin_oe_n_out(oe_n2), .irq_out());
  tcra_pin_src tcra_pin_src_inst (.ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in), .want_in(want), .lag_in(lag), .pin_lvl_out(src));
  initial begin
    ref_clk_in = 1'b0;
    forever #2.5 ref_clk_in = ~ref_clk_in;
  end
  ////////////////////
  task automatic test_done();
    if (n_errors == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : test_done
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // Classic cycle; ack is read before this edge's updates land
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [3:0] s);
    int t;
    @(posedge ref_clk_in);
    cyc  <= 1'b1;
    we   <= w;
    adr  <= a;
    sel  <= s;
    wdat <= d;
    t = 0;
    do begin
      @(posedge ref_clk_in);
      t++;
    end while (ack !== 1'b1 && t < 16);
    if (ack !== 1'b1) begin
      n_errors++;
      test_done();
    end
    rv = rdat;
    cyc <= 1'b0;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hF);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    bus(1'b0, a, 32'h0, 4'hF);
  endtask : rd
  task automatic moving(input logic e);
    rd(8'h0C);
    v = rv;
    rd(8'h0C);
    chk({31'h0, v !== rv}, {31'h0, e});
  endtask : moving
  // Poll until the single-shot bit clears, bounded
  task automatic ss_end();
    rv = 32'h2;
    for (k = 0; k < 30 && rv[1] !== 1'b0; k++) rd(8'h00);
  endtask : ss_end
  ////////////////////
  initial begin
    {cyc, we, latch, want} = 4'h0;
    adr = 8'h00;
    sel = 4'h0;
    lag = 4'h0;
    wdat = 32'h0;
    n_errors = 0;
    n_tests = 0;
    rst_n_in = 1'b0;
    repeat (2) @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    rd(8'h00);
    chk(rv, 32'h0);
    rd(8'h04);
    chk(rv, 32'h0);
    wr(8'h00, 32'hFFFF_FF00);
    bus(1'b1, 8'h00, 32'h08, 4'hE);
    wr(8'h40, 32'hFF);
    rd(8'h40);
    chk(rv, 32'h0);
    rd(8'h00);
    chk(rv, 32'h0);
    wr(8'h0C, 32'h1234);
    moving(1'b0);
    wr(8'h00, 32'h08);
    moving(1'b1);
    wr(8'h00, 32'h10);
    moving(1'b0);
    wr(8'h04, 32'h08);
    moving(1'b1);
    wr(8'h00, 32'h31);
    moving(1'b1);
    wr(8'h04, 32'h00);
    wr(8'h00, 32'h29);
    moving(1'b0);
    lag <= 4'h3;
    want <= 1'b1;
    repeat (12) @(posedge ref_clk_in);
    moving(1'b1);
    wr(8'h0C, 32'h0);
    wr(8'h14, 32'h10);
    wr(8'h00, 32'h88);
    for (k = 0; k < 64 && irq !== 1'b1; k++) @(posedge ref_clk_in);
    chk({31'h0, irq}, 32'h1);
    wr(8'h00, 32'h08);
    @(posedge ref_clk_in);
    chk({31'h0, irq}, 32'h0);
    wr(8'h00, 32'h00);
    wr(8'h08, 32'h0F);
    wr(8'h00, 32'h80);
    repeat (2) @(posedge ref_clk_in);
    chk({31'h0, irq}, 32'h0);
    latch <= 1'b1;
    wr(8'h00, 32'h00);
    repeat (2) @(posedge ref_clk_in);
    chk({30'h0, pout, oe_n}, 32'h3);
    wr(8'h00, 32'h60);
    repeat (2) @(posedge ref_clk_in);
    chk({29'h0, pout, oe_n, oe_n2}, 32'h5);
    wr(8'h00, 32'h00);
    wr(8'h00, 32'h40);
    repeat (2) @(posedge ref_clk_in);
    chk({30'h0, pout, oe_n}, 32'h0);
    wr(8'h00, 32'h60);
    repeat (2) @(posedge ref_clk_in);
    chk({30'h0, pout, oe_n}, 32'h0);
    // Single shot only ever in timer mode
    wr(8'h0C, 32'hFFF0);
    wr(8'h00, 32'h42);
    ss_end();
    chk(rv, 32'h40);
    rd(8'h08);
    chk({31'h0, rv[3]}, 32'h1);
    wr(8'h0C, 32'hFFF0);
    wr(8'h00, 32'h03);
    repeat (40) @(posedge ref_clk_in);
    rd(8'h00);
    chk(rv, 32'h03);
    want <= 1'b0;
    ss_end();
    chk(rv, 32'h01);
    wr(8'h04, 32'h02);
    wr(8'h10, 32'h0100);
    wr(8'h0C, 32'h0);
    wr(8'h00, 32'h0C);
    want <= 1'b1;
    repeat (12) @(posedge ref_clk_in);
    rd(8'h0C);
    chk({24'h0, rv[15:8]}, 32'h01);
    rd(8'h08);
    chk({31'h0, rv[1]}, 32'h1);
    test_done();
  end
endmodule : timer_control_a_run_gate_single_shot_tb
`default_nettype wire
